// [logic/xdo_consts.svh]
/*
  constants for the xor and port direction datapath.
  assumes it is included by bare name from the package and design module.
*/
// Overview of operation
// - literal xor: accumulator xor 8-bit immediate, into accumulator
// - file xor: accumulator xor file register; dest 0 to accumulator
// - file xor with dest 1 writes file register, accumulator unchanged
// - direction load: operand 5, 6, 7 select first, second, third port
// - direction load copies accumulator only and changes no status flag
`ifndef XDO_CONSTS_SVH
`define XDO_CONSTS_SVH

`define XDO_DATA_W 8
`define XDO_ADDR_W 7
`define XDO_OPER_W 3
`define XDO_SEL_FIRST 3'h5
`define XDO_SEL_SECOND 3'h6
`define XDO_SEL_THIRD 3'h7
`define XDO_ACC_RESET 8'h00
`define XDO_DIR_RESET 8'hFF

`endif

// [logic/xdo_pkg.sv]
/*
  types for the xor and port direction datapath.
  assumes the constants header is on the include path.
*/
`include "xdo_consts.svh"

package xdo_pkg;

  // ----------------------------------------
  // operation codes
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    XDO_OP_NONE,
    XDO_OP_XOR_IMMEDIATE,
    XDO_OP_XOR_FILE,
    XDO_OP_LOAD_DIRECTION
  } xdo_op_t;

endpackage : xdo_pkg

// [logic/xdo_datapath.sv]
/*
  execution datapath for literal xor, file xor and direction load.
  assumes the core presents one operation per valid cycle and supplies
  the addressed file register value combinationally on file_rdata.
*/
`timescale 1ns/1ps
`include "xdo_consts.svh"

module xdo_datapath
  import xdo_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire xdo_op_t op_code,
  input wire logic [`XDO_DATA_W-1:0] literal,
  input wire logic [`XDO_ADDR_W-1:0] file_addr,
  input wire logic dest_file,
  input wire logic [`XDO_OPER_W-1:0] dir_sel,
  input wire logic [`XDO_DATA_W-1:0] file_rdata,
  input wire logic carry_in,
  input wire logic digit_carry_in,
  output logic [`XDO_DATA_W-1:0] accumulator,
  output logic zero_flag,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic file_we,
  output logic [`XDO_ADDR_W-1:0] file_waddr,
  output logic [`XDO_DATA_W-1:0] file_wdata,
  output logic [`XDO_DATA_W-1:0] first_port_direction,
  output logic [`XDO_DATA_W-1:0] second_port_direction,
  output logic [`XDO_DATA_W-1:0] third_port_direction,
  output logic bad_operand
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [`XDO_DATA_W-1:0] next_accumulator;
  logic next_zero_flag;
  logic next_carry_flag;
  logic next_digit_carry_flag;
  logic next_file_we;
  logic [`XDO_ADDR_W-1:0] next_file_waddr;
  logic [`XDO_DATA_W-1:0] next_file_wdata;
  logic [`XDO_DATA_W-1:0] next_first_port_direction;
  logic [`XDO_DATA_W-1:0] next_second_port_direction;
  logic [`XDO_DATA_W-1:0] next_third_port_direction;
  logic next_bad_operand;
  logic do_xor_immediate;
  logic do_xor_file;
  logic do_load_direction;
  logic [`XDO_DATA_W-1:0] xor_value;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // both xor paths share one byte-wide xor
  function automatic logic [`XDO_DATA_W-1:0] xor_bytes(
    input logic [`XDO_DATA_W-1:0] left,
    input logic [`XDO_DATA_W-1:0] right
  );
    return left ^ right;
  endfunction : xor_bytes

  // zero test shared by both xor paths
  function automatic logic is_zero(input logic [`XDO_DATA_W-1:0] value);
    return value == '0;
  endfunction : is_zero

  // only three operand codes name a direction register
  function automatic logic is_port_code(input logic [`XDO_OPER_W-1:0] code);
    return code == `XDO_SEL_FIRST || code == `XDO_SEL_SECOND ||
      code == `XDO_SEL_THIRD;
  endfunction : is_port_code

  // ----------------------------------------
  // operation decode
  // ----------------------------------------
  // an op is only acted on while op_valid is high
  always_comb
  begin
    do_xor_immediate = 1'h0;
    do_xor_file = 1'h0;
    do_load_direction = 1'h0;
    xor_value = accumulator;
    if (op_valid)
    begin
      unique case (op_code)
        XDO_OP_NONE:
        begin
          xor_value = accumulator;
        end
        XDO_OP_XOR_IMMEDIATE:
        begin
          do_xor_immediate = 1'h1;
          xor_value = xor_bytes(accumulator, literal);
        end
        XDO_OP_XOR_FILE:
        begin
          do_xor_file = 1'h1;
          xor_value = xor_bytes(accumulator, file_rdata);
        end
        XDO_OP_LOAD_DIRECTION:
        begin
          do_load_direction = 1'h1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // accumulator and zero flag
  // ----------------------------------------
  always_comb
  begin
    next_accumulator = accumulator;
    next_zero_flag = zero_flag;
    if (do_xor_immediate)
    begin
      next_accumulator = xor_value;
    end
    if (do_xor_file && !dest_file)
    begin
      next_accumulator = xor_value;
    end
    if (do_xor_immediate || do_xor_file)
    begin
      next_zero_flag = is_zero(xor_value);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      accumulator <= `XDO_ACC_RESET;
      zero_flag <= 1'h0;
    end
    else
    begin
      accumulator <= next_accumulator;
      zero_flag <= next_zero_flag;
    end
  end

  // ----------------------------------------
  // carry flags
  // ----------------------------------------
  // carries mirror the core one cycle late; no op here computes them
  always_comb
  begin
    next_carry_flag = carry_in;
    next_digit_carry_flag = digit_carry_in;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      carry_flag <= 1'h0;
      digit_carry_flag <= 1'h0;
    end
    else
    begin
      carry_flag <= next_carry_flag;
      digit_carry_flag <= next_digit_carry_flag;
    end
  end

  // ----------------------------------------
  // file register write port
  // ----------------------------------------
  // address and data hold after the pulse so the core may latch late
  always_comb
  begin
    next_file_we = 1'h0;
    next_file_waddr = file_waddr;
    next_file_wdata = file_wdata;
    if (do_xor_file && dest_file)
    begin
      next_file_we = 1'h1;
      next_file_waddr = file_addr;
      next_file_wdata = xor_value;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      file_we <= 1'h0;
      file_waddr <= '0;
      file_wdata <= `XDO_ACC_RESET;
    end
    else
    begin
      file_we <= next_file_we;
      file_waddr <= next_file_waddr;
      file_wdata <= next_file_wdata;
    end
  end

  // ----------------------------------------
  // port direction registers
  // ----------------------------------------
  always_comb
  begin
    next_first_port_direction = first_port_direction;
    next_second_port_direction = second_port_direction;
    next_third_port_direction = third_port_direction;
    if (do_load_direction)
    begin
      unique case (dir_sel)
        `XDO_SEL_FIRST:
        begin
          next_first_port_direction = accumulator;
        end
        `XDO_SEL_SECOND:
        begin
          next_second_port_direction = accumulator;
        end
        `XDO_SEL_THIRD:
        begin
          next_third_port_direction = accumulator;
        end
        // an illegal operand loads nothing; bad_operand reports it
        default:
        begin
          next_first_port_direction = first_port_direction;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // ports come up as inputs until software loads a direction
      first_port_direction <= `XDO_DIR_RESET;
      second_port_direction <= `XDO_DIR_RESET;
      third_port_direction <= `XDO_DIR_RESET;
    end
    else
    begin
      first_port_direction <= next_first_port_direction;
      second_port_direction <= next_second_port_direction;
      third_port_direction <= next_third_port_direction;
    end
  end

  // ----------------------------------------
  // illegal operand report
  // ----------------------------------------
  always_comb
  begin
    next_bad_operand = do_load_direction && !is_port_code(dir_sel);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bad_operand <= 1'h0;
    end
    else
    begin
      bad_operand <= next_bad_operand;
    end
  end

endmodule : xdo_datapath

// [testbench/xdo_props.sv]
/* checker on the datapath ports, bound in from the bench top */
`timescale 1ns/1ps
module xdo_props import xdo_pkg::*; (
  input wire logic clk, rst, op_valid, dest_file, zero_flag, file_we,
  input wire logic bad_operand, carry_in, carry_flag,
  input wire xdo_op_t op_code,
  input wire logic [2:0] dir_sel,
  input wire logic [7:0] literal, file_rdata, accumulator,
  input wire logic [7:0] first_port_direction, third_port_direction
);
  wire im = op_valid && op_code == XDO_OP_XOR_IMMEDIATE;
  wire fl = op_valid && op_code == XDO_OP_XOR_FILE;
  wire ld = op_valid && op_code == XDO_OP_LOAD_DIRECTION;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  lit_xor_a: assert property (im |=> accumulator ==
    ($past(accumulator) ^ $past(literal))) else $error("literal xor wrong");
  file_acc_a: assert property (fl && !dest_file |=>
    accumulator == ($past(accumulator) ^ $past(file_rdata)))
    else $error("file xor into accumulator wrong");
  file_dst_a: assert property (fl && dest_file |=>
    file_we && $stable(accumulator)) else $error("file xor writeback wrong");
  dir_first_a: assert property (ld && dir_sel == 3'h5 |=>
    first_port_direction == $past(accumulator))
    else $error("first port direction not loaded");
  dir_bad_a: assert property (ld && dir_sel < 3'h5 |=> bad_operand &&
    $stable(first_port_direction) && $stable(third_port_direction))
    else $error("illegal operand changed a port");
  dir_flag_a: assert property (ld |=>
    $stable(zero_flag) && $stable(accumulator))
    else $error("direction load changed state");
  dir_we_a: assert property (ld |=> !file_we)
    else $error("direction load wrote a file register");
  zero_lit_a: assert property (im |=>
    zero_flag == (accumulator == 8'h00)) else $error("zero flag wrong");
  zero_file_a: assert property (fl |=> zero_flag ==
    (($past(accumulator) ^ $past(file_rdata)) == 8'h00))
    else $error("file xor zero flag wrong");
  carry_keep_a: assert property (im || fl |=>
    carry_flag == $past(carry_in)) else $error("xor changed carry");
endmodule : xdo_props

// [testbench/xdo_file_model.sv]
/* file registers; a write in flight is forwarded so back-to-back ops
   read the fresh value, as the core would */
`timescale 1ns/1ps
module xdo_file_model (
  input wire logic clk, file_we,
  input wire logic [6:0] file_addr, file_waddr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [128];
  initial foreach (mem[i]) mem[i] = 8'(i * 8'h25);
  always @(posedge clk) if (file_we) mem[file_waddr] <= file_wdata;
  assign file_rdata = file_we && file_waddr == file_addr ? file_wdata :
    mem[file_addr];
endmodule : xdo_file_model

// [testbench/xdo_datapath_tb_top.sv]
/* random op stream against an integer model; needs checker and file model */
`timescale 1ns/1ps
module xdo_datapath_tb_top import xdo_pkg::*; ;
  logic clk = '0, rst = '1, op_valid = '0, dest_file = '0, carry_in = '0;
  logic digit_carry_in = '0, zero_flag, carry_flag, digit_carry_flag;
  logic file_we, bad_operand, z = '0, c = '0, dc = '0, we = '0, bad = '0;
  logic [7:0] literal = '0, file_rdata, accumulator, file_wdata;
  logic [7:0] first_port_direction, second_port_direction;
  logic [7:0] third_port_direction;
  logic [6:0] file_addr = '0, file_waddr;
  logic [2:0] dir_sel = '0;
  logic [31:0] r;
  xdo_op_t op_code = XDO_OP_NONE;
  int seed = 32'h4422, miscompares = 0, cmp_count = 0, acc = 0, wd, wa, x;
  int dirs = 24'hFFFFFF, fm [128];
  wire [4:0] flags = {zero_flag, carry_flag, digit_carry_flag, file_we,
    bad_operand};
  wire [23:0] dirv = {first_port_direction, second_port_direction,
    third_port_direction};
  xdo_datapath xdo_datapath_i (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .literal(literal), .file_addr(file_addr), .dest_file(dest_file),
    .dir_sel(dir_sel), .file_rdata(file_rdata), .carry_in(carry_in),
    .digit_carry_in(digit_carry_in), .accumulator(accumulator),
    .zero_flag(zero_flag), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata),
    .first_port_direction(first_port_direction),
    .second_port_direction(second_port_direction),
    .third_port_direction(third_port_direction),
    .bad_operand(bad_operand));
  xdo_file_model xdo_file_model_i (
    .clk(clk), .file_we(file_we), .file_addr(file_addr),
    .file_waddr(file_waddr), .file_wdata(file_wdata),
    .file_rdata(file_rdata));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [23:0] g, input int v);
    cmp_count++;
    if (g !== 24'(v)) $display("MISMATCH %0t got %h want %h", $time, g,
      24'(v));
    if (g !== 24'(v)) miscompares++;
  endtask : chk
  task automatic check_outputs;
    chk(accumulator, acc);
    chk(flags, {z, c, dc, we, bad});
    chk(dirv, dirs);
    if (we) chk(file_wdata, wd);
    if (we) chk(file_waddr, wa);
  endtask : check_outputs
  task automatic run_random(input int n);
    repeat (n)
    begin
      @(posedge clk);
      r = $random(seed);
      op_valid <= r[23];
      op_code <= xdo_op_t'(r[1:0]);
      digit_carry_in <= r[22];
      {carry_in, dir_sel, dest_file, file_addr, literal} <= r[21:2];
      #1 check_outputs();
      if (!r[23]) r[1:0] = 2'h0;
      c = r[21];
      dc = r[22];
      x = (r[0] ? r[9:2] : fm[r[16:10]]) ^ acc;
      wd = x;
      wa = r[16:10];
      bad = &r[1:0] && r[20:18] < 3'h5;
      we = r[1] && !r[0] && r[17];
      if (&r[1:0] && !bad) dirs[8 * (7 - r[20:18]) +: 8] = acc;
      if (r[1] ^ r[0]) z = x == 0;
      if (we) fm[r[16:10]] = x;
      if (!we && (r[1] ^ r[0])) acc = x;
    end
    // let the last op land so its result is looked at too
    @(posedge clk);
    op_valid <= '0;
    #1 check_outputs();
  endtask : run_random
  task automatic pulse_reset;
    @(posedge clk);
    rst <= '1;
    carry_in <= '0;
    digit_carry_in <= '0;
    repeat (2) @(posedge clk);
    acc = 0;
    z = '0;
    c = '0;
    dc = '0;
    we = '0;
    bad = '0;
    dirs = 24'hFFFFFF;
    #1 check_outputs();
    chk(file_wdata, 0);
    chk(file_waddr, 0);
    @(posedge clk);
    rst <= '0;
  endtask : pulse_reset
  task automatic finish_test(input int hung);
    miscompares += hung;
    $display("%0d checks %0d bad", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial #20000 finish_test(1);
  initial
  begin
    foreach (fm[i]) fm[i] = 8'(i * 8'h25);
    repeat (4) @(posedge clk);
    rst <= '0;
    run_random(300);
    $display("random ops done");
    pulse_reset();
    $display("mid-run reset done");
    run_random(100);
    $display("random ops after reset done");
    finish_test(0);
  end
endmodule : xdo_datapath_tb_top
bind xdo_datapath xdo_props xdo_props_i (
  .clk(clk), .rst(rst), .op_valid(op_valid), .dest_file(dest_file),
  .zero_flag(zero_flag), .file_we(file_we), .bad_operand(bad_operand),
  .carry_in(carry_in), .carry_flag(carry_flag), .op_code(op_code),
  .dir_sel(dir_sel), .literal(literal), .file_rdata(file_rdata),
  .accumulator(accumulator), .first_port_direction(first_port_direction),
  .third_port_direction(third_port_direction));
